// ===== rtl/lcdk_defs.svh
// register map, field positions, reset values and timing of the lcd core
// assumes a 32-bit apb bus and a 20 MHz core clock
`ifndef LCDK_DEFS_SVH
`define LCDK_DEFS_SVH
`define LCDK_OFS_CTRL 8'h00
`define LCDK_OFS_CMD 8'h04
`define LCDK_OFS_PTR 8'h08
`define LCDK_OFS_DATA 8'h0c
`define LCDK_OFS_LED 8'h10
`define LCDK_OFS_KEY 8'h14
`define LCDK_OFS_STATUS 8'h18
`define LCDK_OFS_IRQ_STAT 8'h1c
`define LCDK_OFS_IRQ_MASK 8'h20
`define LCDK_CMD_CLEAR 0
`define LCDK_CMD_WAKE 1
`define LCDK_CTRL_RST 9'h043
`define LCDK_BLANK_CODE 8'h20
`define LCDK_IRQ_KEY_DN 0
`define LCDK_IRQ_KEY_UP 1
`define LCDK_IRQ_REFUSED 2
`define LCDK_IRQ_DONE 3
`define LCDK_CELLS 4'ha
`define LCDK_LAST_ROW_1L 5'h08
`define LCDK_LAST_ROW_2L 5'h10
`define LCDK_GLYPH_ROWS 3'h7
`define LCDK_KEY_LAST_ROW 3'h5
`define LCDK_CLK_NS 50
`define LCDK_EXEC_NS 2000
`define LCDK_EXEC_CYC ((`LCDK_EXEC_NS + `LCDK_CLK_NS - 1) / `LCDK_CLK_NS)
`endif

// ===== rtl/lcdk_pkg.sv
// types shared by the lcd core: bus carriers, configuration and states
// assumes nothing beyond a systemverilog compiler
package lcdk_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lcdk_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lcdk_apb_rsp_t;
  // bit 0 is the line-count selection; ks holds timing bits one, two, three
  typedef struct packed {
    logic [2:0] ks;
    logic blink_en;
    logic cur_en;
    logic disp_en;
    logic shift;
    logic inc;
    logic two_line;
  } lcdk_cfg_t;
  typedef enum logic [1:0] {SPACE_CHAR, SPACE_FONT, SPACE_ICON} lcdk_space_t;
  typedef enum logic [1:0] {KS_IDLE, KS_PRESS_WAIT, KS_HELD, KS_REL_WAIT} lcdk_ks_state_t;
endpackage

// ===== rtl/lcdk_core.sv
// character lcd core: display refresh, cursor, led register, key scan, apb registers
// assumes OSC_CLK_IN and KEY_COL_N_IN come from outside the core clock domain
// What this block does
// - timing sequences all three memory reads
// - host writes never disturb refresh
// - seventeen common and fifty segment outputs
// - unused commons get non-select level
// - cursor at cell addressed by pointer
// - same cursor logic for other memories
// - three-bit led register drives open drains
// - scan six by six key matrix
// - combined key data for multiple keys
// - reset then standby until host wakes
// - standby accepts only wake, led and irq mask writes
// - reset equals cleared state, leds off
// - reset selects two-line display
// - reset: increment, no shift
// - reset: display, cursor, blink off
// - reset key timing gives 1500/2400 debounce
// - busy flag refuses most commands
// - pointer steps after each data access
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "lcdk_defs.svh"
module lcdk_core #(
  parameter int PRESS_DEB_TICKS = 1500,
  parameter int RELEASE_DEB_TICKS = 2400,
  parameter int BLINK_TICKS = 16384,
  parameter int ROW_TICKS = 4
) (
  input logic CORE_CLK_IN,
  input logic RSTN_IN,
  input lcdk_pkg::lcdk_apb_req_t APB_REQ_IN,
  output lcdk_pkg::lcdk_apb_rsp_t APB_RSP_OUT,
  input logic OSC_CLK_IN,
  output logic [16:0] COM_OUT,
  output logic [49:0] SEG_OUT,
  output logic [2:0] LED_OUT,
  output logic [2:0] LED_OE_N_OUT,
  output logic [5:0] KEY_ROW_OUT,
  output logic [5:0] KEY_ROW_OE_N_OUT,
  input logic [5:0] KEY_COL_N_IN,
  output logic KD_OUT,
  output logic KD_OE_N_OUT,
  output logic IRQ_OUT
);
  import lcdk_pkg::*;

  if (ROW_TICKS < 2 || ROW_TICKS > 255 || PRESS_DEB_TICKS < 8 || PRESS_DEB_TICKS > 16383 ||
      RELEASE_DEB_TICKS < 8 || RELEASE_DEB_TICKS > 16383 || BLINK_TICKS < 1 ||
      BLINK_TICKS > 65535) begin : g_bad_param
    $error("lcdk_core: unsupported parameter value");
  end

  logic [2:0] osc_sync_q;
  logic [5:0] col_s1_q;
  logic [5:0] col_s2_q;
  logic osc_tick;
  lcdk_apb_rsp_t rsp_q;
  logic acc_en, done, wr, rd;
  logic [31:0] rdata_d;
  logic addr_hit;
  logic op_cfg, op_clr, op_wake, op_ptr, op_dwr, op_drd, op_led, gated_try;
  logic go, go_cfg, go_clr, go_ptr, go_dwr, go_drd, wake_go, refused;
  logic [5:0] busy_cnt_q;
  logic busy;
  logic standby_q;
  lcdk_cfg_t cfg_q;
  logic [5:0] ptr_q;
  lcdk_space_t space_q;
  logic clear_flag_q;
  logic [2:0] led_q;
  logic [3:0] mask_q, irq_stat_q, irq_ev, irq_stat_d;
  logic irq_q;
  logic [7:0] char_mem_q [32];
  logic [4:0] font_mem_q [64];
  logic [5:0] icon_mem_q [16];
  logic [7:0] mem_rd;
  logic [7:0] row_div_q;
  logic row_adv;
  logic [4:0] row_q, last_row;
  logic [3:0] cell_q;
  logic [49:0] shadow_q;
  logic [16:0] com_q;
  logic [49:0] seg_q;
  logic [15:0] blink_cnt_q;
  logic blink_q;
  logic line, icon_row, cell_hit;
  logic [2:0] glyph_row;
  logic [4:0] cell_addr;
  logic [7:0] code;
  logic [4:0] font_bits, icon_bits, dots;
  logic [5:0] icon_word;
  logic [2:0] ks_row_q;
  logic [5:0] row_oe_n_q, acc_rows_q, acc_cols_q, pressed_cols;
  logic [11:0] raw_q, key_q;
  lcdk_ks_state_t ks_st_q;
  logic [15:0] deb_cnt_q, press_lim, rel_lim;
  logic key_dn_q, key_up_q, kd_oe_n_q, pin_low_q;
  logic [2:0] led_oe_n_q;

  // stand-in glyph generator; a product ships its own glyph table here
  function automatic logic [4:0] font_row(input logic [7:0] c, input logic [2:0] r);
    font_row = (r == `LCDK_GLYPH_ROWS) ? 5'h00 : (c[4:0] ^ {c[7:5], r[1:0]});
  endfunction

  // the second and third flops of the chain feed the edge detector
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      osc_sync_q <= 3'h0;
      col_s1_q <= 6'h3f;
      col_s2_q <= 6'h3f;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], OSC_CLK_IN};
      col_s1_q <= KEY_COL_N_IN;
      col_s2_q <= col_s1_q;
    end
  end
  assign osc_tick = osc_sync_q[1] & ~osc_sync_q[2];

  // apb: one wait state so the answer comes from flops
  assign acc_en = APB_REQ_IN.psel & APB_REQ_IN.penable;
  assign done = acc_en & rsp_q.pready;
  assign wr = done & APB_REQ_IN.pwrite;
  assign rd = done & ~APB_REQ_IN.pwrite;

  always_comb begin
    rdata_d = 32'h0;
    addr_hit = 1'b1;
    if (APB_REQ_IN.paddr == `LCDK_OFS_CTRL) begin
      rdata_d = {23'h0, cfg_q};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_CMD) begin
      rdata_d = 32'h0;
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_PTR) begin
      rdata_d = {22'h0, space_q, 2'h0, ptr_q};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_DATA) begin
      rdata_d = {24'h0, mem_rd};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_LED) begin
      rdata_d = {29'h0, led_q};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_KEY) begin
      rdata_d = {19'h0, ks_st_q == KS_HELD || ks_st_q == KS_REL_WAIT, key_q};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_STATUS) begin
      rdata_d = {29'h0, clear_flag_q, standby_q, busy};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_IRQ_STAT) begin
      rdata_d = {28'h0, irq_stat_q};
    end else if (APB_REQ_IN.paddr == `LCDK_OFS_IRQ_MASK) begin
      rdata_d = {28'h0, mask_q};
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= acc_en & ~rsp_q.pready;
      rsp_q.prdata <= (acc_en & ~rsp_q.pready) ? rdata_d : 32'h0;
      rsp_q.pslverr <= acc_en & ~rsp_q.pready & ~addr_hit;
    end
  end

  assign op_cfg = wr && APB_REQ_IN.paddr == `LCDK_OFS_CTRL;
  assign op_clr = wr && APB_REQ_IN.paddr == `LCDK_OFS_CMD && APB_REQ_IN.pwdata[`LCDK_CMD_CLEAR];
  assign op_wake = wr && APB_REQ_IN.paddr == `LCDK_OFS_CMD && APB_REQ_IN.pwdata[`LCDK_CMD_WAKE];
  assign op_ptr = wr && APB_REQ_IN.paddr == `LCDK_OFS_PTR;
  assign op_dwr = wr && APB_REQ_IN.paddr == `LCDK_OFS_DATA;
  assign op_drd = rd && APB_REQ_IN.paddr == `LCDK_OFS_DATA;
  assign op_led = wr && APB_REQ_IN.paddr == `LCDK_OFS_LED;
  assign gated_try = op_cfg | op_clr | op_ptr | op_dwr | op_drd;
  assign go = ~busy & ~standby_q;
  assign go_cfg = op_cfg & go;
  assign go_clr = op_clr & go;
  assign go_ptr = op_ptr & go;
  assign go_dwr = op_dwr & go;
  assign go_drd = op_drd & go;
  assign wake_go = op_wake & ~busy;
  assign refused = (gated_try & ~go) | (op_wake & busy);

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      busy_cnt_q <= 6'h0;
    end else if ((gated_try & go) | wake_go) begin
      busy_cnt_q <= 6'(`LCDK_EXEC_CYC);
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q - 6'h1;
    end
  end
  assign busy = busy_cnt_q != 6'h0;

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      standby_q <= 1'b1;
      cfg_q <= `LCDK_CTRL_RST;
    end else begin
      if (wake_go) begin
        standby_q <= 1'b0;
      end
      if (go_cfg) begin
        cfg_q <= APB_REQ_IN.pwdata[8:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ptr_q <= 6'h0;
      space_q <= SPACE_CHAR;
    end else if (go_clr) begin
      ptr_q <= 6'h0;
      space_q <= SPACE_CHAR;
    end else if (go_ptr) begin
      ptr_q <= APB_REQ_IN.pwdata[5:0];
      space_q <= lcdk_space_t'(APB_REQ_IN.pwdata[9:8]);
    end else if (go_dwr | go_drd) begin
      ptr_q <= cfg_q.inc ? ptr_q + 6'h1 : ptr_q - 6'h1;
    end
  end

  // led register, exempt from busy and standby
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      clear_flag_q <= 1'b1;
      led_q <= 3'h0;
    end else begin
      if (go_clr) begin
        clear_flag_q <= 1'b1;
      end else if (go_dwr) begin
        clear_flag_q <= 1'b0;
      end
      if (op_led) begin
        led_q <= APB_REQ_IN.pwdata[2:0];
      end else if (go_clr) begin
        led_q <= 3'h0;
      end
    end
  end

  // a new event wins over the read that clears the status; only reported bits clear,
  // so an event landing between the data capture and the clear edge is not lost
  always_comb begin
    irq_ev = 4'h0;
    irq_ev[`LCDK_IRQ_KEY_DN] = key_dn_q;
    irq_ev[`LCDK_IRQ_KEY_UP] = key_up_q;
    irq_ev[`LCDK_IRQ_REFUSED] = refused;
    irq_ev[`LCDK_IRQ_DONE] = busy_cnt_q == 6'h1;
    irq_stat_d = irq_stat_q;
    if (rd && APB_REQ_IN.paddr == `LCDK_OFS_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~rsp_q.prdata[3:0];
    end
    irq_stat_d = irq_stat_d | irq_ev;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      irq_stat_q <= 4'h0;
      mask_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & mask_q);
      if (wr && APB_REQ_IN.paddr == `LCDK_OFS_IRQ_MASK) begin
        mask_q <= APB_REQ_IN.pwdata[3:0];
      end
    end
  end

  // host port writes, refresh only reads
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 32; i++) char_mem_q[i] <= `LCDK_BLANK_CODE;
      for (int i = 0; i < 64; i++) font_mem_q[i] <= 5'h0;
      for (int i = 0; i < 16; i++) icon_mem_q[i] <= 6'h0;
    end else if (go_clr) begin
      for (int i = 0; i < 32; i++) char_mem_q[i] <= `LCDK_BLANK_CODE;
    end else if (go_dwr) begin
      case (space_q)
        SPACE_CHAR: char_mem_q[ptr_q[4:0]] <= APB_REQ_IN.pwdata[7:0];
        SPACE_FONT: font_mem_q[ptr_q] <= APB_REQ_IN.pwdata[4:0];
        default: icon_mem_q[ptr_q[3:0]] <= APB_REQ_IN.pwdata[5:0];
      endcase
    end
  end

  always_comb begin
    case (space_q)
      SPACE_CHAR: mem_rd = char_mem_q[ptr_q[4:0]];
      SPACE_FONT: mem_rd = {3'h0, font_mem_q[ptr_q]};
      default: mem_rd = {2'h0, icon_mem_q[ptr_q[3:0]]};
    endcase
  end

  assign row_adv = osc_tick && row_div_q == 8'(ROW_TICKS - 1);
  assign last_row = cfg_q.two_line ? `LCDK_LAST_ROW_2L : `LCDK_LAST_ROW_1L;
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      row_div_q <= 8'h0;
      row_q <= 5'h0;
      cell_q <= 4'h0;
    end else begin
      if (row_adv) begin
        row_div_q <= 8'h0;
      end else if (osc_tick) begin
        row_div_q <= row_div_q + 8'h1;
      end
      if (row_adv) begin
        row_q <= (row_q >= last_row) ? 5'h0 : row_q + 5'h1;
        cell_q <= 4'h0;
      end else if (cell_q < `LCDK_CELLS) begin
        cell_q <= cell_q + 4'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      blink_cnt_q <= 16'h0;
      blink_q <= 1'b0;
    end else if (osc_tick) begin
      if (blink_cnt_q == 16'(BLINK_TICKS - 1)) begin
        blink_cnt_q <= 16'h0;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 16'h1;
      end
    end
  end

  always_comb begin
    line = cfg_q.two_line & row_q[3];
    icon_row = row_q == last_row;
    glyph_row = row_q[2:0];
    cell_addr = {line, cell_q};
    code = char_mem_q[cell_addr];
    font_bits = (code[7:4] == 4'h0) ? font_mem_q[{code[2:0], glyph_row}] :
      font_row(code, glyph_row);
    cell_hit = ptr_q == {1'b0, cell_addr};
    if (cfg_q.cur_en && cell_hit && glyph_row == `LCDK_GLYPH_ROWS) begin
      font_bits = 5'h1f;
    end
    if (cfg_q.blink_en && cell_hit && blink_q) begin
      font_bits = ~font_bits;
    end
    icon_word = icon_mem_q[cell_q];
    icon_bits = icon_word[4:0] & ~{5{icon_word[5] & blink_q}};
    dots = icon_row ? icon_bits : {font_bits[0], font_bits[1], font_bits[2], font_bits[3],
      font_bits[4]};
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      shadow_q <= 50'h0;
      com_q <= 17'h0;
      seg_q <= 50'h0;
    end else begin
      if (!row_adv && cell_q < `LCDK_CELLS) begin
        shadow_q[cell_q * 5 +: 5] <= dots;
      end
      if (row_adv) begin
        com_q <= (cfg_q.disp_en && !standby_q) ? (17'h1 << row_q) : 17'h0;
        seg_q <= (cfg_q.disp_en && !standby_q) ? shadow_q : 50'h0;
      end
    end
  end

  assign pressed_cols = ~col_s2_q;
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ks_row_q <= 3'h0;
      row_oe_n_q <= 6'h3e;
      acc_rows_q <= 6'h0;
      acc_cols_q <= 6'h0;
      raw_q <= 12'h0;
    end else if (osc_tick) begin
      if (ks_row_q == `LCDK_KEY_LAST_ROW) begin
        ks_row_q <= 3'h0;
        row_oe_n_q <= 6'h3e;
        raw_q <= {acc_cols_q | pressed_cols,
          acc_rows_q | ((|pressed_cols) ? (6'h1 << ks_row_q) : 6'h0)};
        acc_rows_q <= 6'h0;
        acc_cols_q <= 6'h0;
      end else begin
        ks_row_q <= ks_row_q + 3'h1;
        row_oe_n_q <= ~(6'h1 << (ks_row_q + 3'h1));
        acc_rows_q <= acc_rows_q | ((|pressed_cols) ? (6'h1 << ks_row_q) : 6'h0);
        acc_cols_q <= acc_cols_q | pressed_cols;
      end
    end
  end

  assign press_lim = (cfg_q.ks[0] ? 16'(PRESS_DEB_TICKS) : 16'(2 * PRESS_DEB_TICKS)) >>
    cfg_q.ks[2:1];
  assign rel_lim = (cfg_q.ks[0] ? 16'(RELEASE_DEB_TICKS) : 16'(2 * RELEASE_DEB_TICKS)) >>
    cfg_q.ks[2:1];

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ks_st_q <= KS_IDLE;
      deb_cnt_q <= 16'h0;
      key_q <= 12'h0;
      key_dn_q <= 1'b0;
      key_up_q <= 1'b0;
    end else begin
      key_dn_q <= 1'b0;
      key_up_q <= 1'b0;
      if (osc_tick) begin
        deb_cnt_q <= deb_cnt_q + 16'h1;
        case (ks_st_q)
          KS_IDLE: begin
            deb_cnt_q <= 16'h0;
            if (raw_q != 12'h0) ks_st_q <= KS_PRESS_WAIT;
          end
          KS_PRESS_WAIT: begin
            if (raw_q == 12'h0) begin
              ks_st_q <= KS_IDLE;
            end else if (deb_cnt_q >= press_lim - 16'h1) begin
              ks_st_q <= KS_HELD;
              key_q <= raw_q;
              key_dn_q <= 1'b1;
            end
          end
          KS_HELD: begin
            deb_cnt_q <= 16'h0;
            if (raw_q == 12'h0) begin
              ks_st_q <= KS_REL_WAIT;
            end else begin
              key_q <= raw_q;
            end
          end
          default: begin
            if (raw_q != 12'h0) begin
              ks_st_q <= KS_HELD;
            end else if (deb_cnt_q >= rel_lim - 16'h1) begin
              ks_st_q <= KS_IDLE;
              key_up_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // open-drain pins only ever pull low, so their data flop stays at zero
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pin_low_q <= 1'b0;
      kd_oe_n_q <= 1'b1;
      led_oe_n_q <= 3'h7;
    end else begin
      pin_low_q <= 1'b0;
      led_oe_n_q <= ~led_q;
      kd_oe_n_q <= !(ks_st_q == KS_HELD || ks_st_q == KS_REL_WAIT);
    end
  end

  assign APB_RSP_OUT = rsp_q;
  assign COM_OUT = com_q;
  assign SEG_OUT = seg_q;
  assign LED_OUT = {3{pin_low_q}};
  // led bit on pulls its pin
  assign LED_OE_N_OUT = led_oe_n_q;
  assign KEY_ROW_OUT = {6{pin_low_q}};
  assign KEY_ROW_OE_N_OUT = row_oe_n_q;
  assign KD_OUT = pin_low_q;
  assign KD_OE_N_OUT = kd_oe_n_q;
  assign IRQ_OUT = irq_q;
endmodule

// ===== verification/lcdk_core_chk.sv
// checker for the lcd core: bus timing, drive outputs and key scan rows
// assumes it is bound to the core and sees only its top ports
`timescale 1ns/1ps
module lcdk_core_chk (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire lcdk_pkg::lcdk_apb_req_t APB_REQ_IN,
  input wire lcdk_pkg::lcdk_apb_rsp_t APB_RSP_OUT,
  input wire logic [16:0] COM_OUT,
  input wire logic [49:0] SEG_OUT,
  input wire logic [2:0] LED_OUT,
  input wire logic [5:0] KEY_ROW_OUT,
  input wire logic [5:0] KEY_ROW_OE_N_OUT,
  input wire logic KD_OUT
);
  import lcdk_pkg::*;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  sequence s_access;
    APB_REQ_IN.psel && !APB_REQ_IN.penable ##1 APB_REQ_IN.psel && APB_REQ_IN.penable;
  endsequence
  sequence s_answer;
    !APB_RSP_OUT.pready ##1 APB_RSP_OUT.pready ##1 !APB_RSP_OUT.pready;
  endsequence
  property p_one_wait;
    s_access |-> s_answer;
  endproperty
  property p_no_spurious;
    APB_RSP_OUT.pready |-> APB_REQ_IN.psel && APB_REQ_IN.penable && $past(APB_REQ_IN.penable);
  endproperty
  property p_err_unmapped;
    APB_RSP_OUT.pready && APB_REQ_IN.paddr[1:0] == 2'h0
      |-> APB_RSP_OUT.pslverr == (APB_REQ_IN.paddr > 8'h20);
  endproperty
  property p_rdata_idle;
    !APB_RSP_OUT.pready |-> APB_RSP_OUT.prdata == 32'h0 && !APB_RSP_OUT.pslverr;
  endproperty
  property p_com_onehot;
    $onehot0(COM_OUT);
  endproperty
  property p_blank;
    COM_OUT == 17'h0 |-> SEG_OUT == 50'h0;
  endproperty
  property p_open_drain_data;
    LED_OUT == 3'h0 && KEY_ROW_OUT == 6'h0 && !KD_OUT;
  endproperty
  property p_rows_one_cold;
    $onehot(~KEY_ROW_OE_N_OUT);
  endproperty
  // a row is held for a whole oscillator tick, far more than four core cycles
  property p_row_scan;
    $changed(KEY_ROW_OE_N_OUT) |=> $stable(KEY_ROW_OE_N_OUT) [*4];
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not one wait state");
  a_no_spurious: assert property (p_no_spurious) else $error("pready without access");
  a_err_unmapped: assert property (p_err_unmapped) else $error("bad slave error");
  a_rdata_idle: assert property (p_rdata_idle) else $error("response outside answer");
  a_com_onehot: assert property (p_com_onehot) else $error("several commons select");
  a_blank: assert property (p_blank) else $error("segments on with no common");
  a_open_drain_data: assert property (p_open_drain_data) else $error("drain data high");
  a_rows_one_cold: assert property (p_rows_one_cold) else $error("key rows not one");
  a_row_scan: assert property (p_row_scan) else $error("key row too short");
endmodule

// ===== verification/lcdk_keypad_model.sv
// key matrix model: single-contact switches joining row and column lines
// assumes rows are pulled low only when enabled and columns have pull-ups
`timescale 1ns/1ps
module lcdk_keypad_model (
  input wire logic [5:0] row_oe_n_in,
  input wire logic [35:0] pressed_in,
  output logic [5:0] col_n_out
);
  always_comb begin
    col_n_out = 6'h3f;
    for (int r = 0; r < 6; r++) begin
      for (int c = 0; c < 6; c++) begin
        if (pressed_in[r*6+c] && !row_oe_n_in[r]) begin
          col_n_out[c] = 1'b0;
        end
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the lcd core with a key matrix model
// assumes shortened debounce and blink counts; oscillator free-running
`timescale 1ns/1ps
`include "lcdk_defs.svh"
module testbench;
  import lcdk_pkg::*;
  logic clk;
  logic rst_n;
  logic osc;
  lcdk_apb_req_t req;
  lcdk_apb_rsp_t rsp;
  logic [16:0] com;
  logic [49:0] seg;
  logic [2:0] led_oe_n;
  logic [5:0] row_oe_n;
  logic [5:0] col_n;
  logic kd_oe_n;
  logic irq;
  logic [35:0] keys;
  logic [31:0] rd;
  logic err;
  int err_total;
  int samples_checked;
  lcdk_core #(.PRESS_DEB_TICKS(8), .RELEASE_DEB_TICKS(8), .BLINK_TICKS(4), .ROW_TICKS(4))
    i_lcdk_core (.CORE_CLK_IN(clk), .RSTN_IN(rst_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .OSC_CLK_IN(osc), .COM_OUT(com), .SEG_OUT(seg), .LED_OUT(), .LED_OE_N_OUT(led_oe_n),
    .KEY_ROW_OUT(), .KEY_ROW_OE_N_OUT(row_oe_n), .KEY_COL_N_IN(col_n), .KD_OUT(),
    .KD_OE_N_OUT(kd_oe_n), .IRQ_OUT(irq));
  lcdk_keypad_model i_lcdk_keypad_model (.row_oe_n_in(row_oe_n), .pressed_in(keys),
    .col_n_out(col_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #13;
    forever #200 osc = ~osc;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic fail_wait(input string what);
    check(what, 32'h0, 32'h1);
    test_done();
  endtask
  // request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) fail_wait("apb ready");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `LCDK_OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    if (n >= 50) fail_wait("busy clear");
  endtask
  task automatic cmd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    wait_idle();
  endtask
  task automatic t_reset();
    check("led pins", led_oe_n, 3'h7);
    check("commons", com, 17'h0);
    rdc("ctrl", `LCDK_OFS_CTRL, 32'h43);
    rdc("status", `LCDK_OFS_STATUS, 32'h6);
  endtask
  task automatic t_standby();
    apb(1'b1, `LCDK_OFS_IRQ_MASK, 32'h4);
    apb(1'b1, `LCDK_OFS_CTRL, 32'h5b);
    rdc("ctrl kept", `LCDK_OFS_CTRL, 32'h43);
    check("irq up", irq, 32'h1);
    rdc("refused", `LCDK_OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    check("irq down", irq, 32'h0);
    apb(1'b1, `LCDK_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `LCDK_OFS_CMD, 32'h1);
    check("irq masked", irq, 32'h0);
    rdc("refused clear", `LCDK_OFS_IRQ_STAT, 32'h4);
    apb(1'b1, `LCDK_OFS_LED, 32'h5);
    rdc("led reg", `LCDK_OFS_LED, 32'h5);
    check("led pins on", led_oe_n, 3'h2);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `LCDK_OFS_CMD, 32'h2);
    apb(1'b0, `LCDK_OFS_STATUS, 32'h0);
    check("busy", rd[0], 32'h1);
    apb(1'b1, `LCDK_OFS_CTRL, 32'h5b);
    wait_idle();
    rdc("ctrl busy", `LCDK_OFS_CTRL, 32'h43);
    rdc("wake irq", `LCDK_OFS_IRQ_STAT, 32'hc);
    rdc("awake", `LCDK_OFS_STATUS, 32'h4);
  endtask
  task automatic t_pointer();
    cmd(`LCDK_OFS_CTRL, 32'h5b);
    cmd(`LCDK_OFS_PTR, 32'h0);
    cmd(`LCDK_OFS_DATA, 32'h41);
    rdc("ptr inc", `LCDK_OFS_PTR, 32'h1);
    cmd(`LCDK_OFS_CTRL, 32'h59);
    cmd(`LCDK_OFS_DATA, 32'h42);
    cmd(`LCDK_OFS_DATA, 32'h43);
    rdc("ptr wrap", `LCDK_OFS_PTR, 32'h3f);
    cmd(`LCDK_OFS_PTR, 32'h1);
    rdc("data", `LCDK_OFS_DATA, 32'h42);
    wait_idle();
    rdc("ptr read", `LCDK_OFS_PTR, 32'h0);
    cmd(`LCDK_OFS_PTR, 32'h105);
    cmd(`LCDK_OFS_DATA, 32'h1f);
    rdc("ptr font", `LCDK_OFS_PTR, 32'h104);
    cmd(`LCDK_OFS_CTRL, 32'h5b);
    rdc("dirty", `LCDK_OFS_STATUS, 32'h0);
    cmd(`LCDK_OFS_CMD, 32'h1);
    rdc("cleared", `LCDK_OFS_STATUS, 32'h4);
    rdc("ptr home", `LCDK_OFS_PTR, 32'h0);
    check("leds off", led_oe_n, 3'h7);
  endtask
  // settle a frame first so a row left from the old mode is not counted
  task automatic scan_com(input logic [16:0] exp);
    logic [16:0] seen;
    seen = '0;
    repeat (600) @(posedge clk);
    repeat (1200) begin
      @(posedge clk);
      seen = seen | com;
    end
    check("commons used", seen, exp);
  endtask
  task automatic t_cursor();
    logic [8:0] ptr[4] = '{9'h008, 9'h108, 9'h208, 9'h012};
    int n;
    int r;
    for (int i = 0; i < 4; i++) begin
      cmd(`LCDK_OFS_PTR, {23'h0, ptr[i]});
      r = ptr[i][4] ? 15 : 7;
      // let a row built with the old pointer leave the outputs first
      repeat (64) @(posedge clk);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (com[r] !== 1'b1 && n < 2000);
      if (n >= 2000) fail_wait("cursor row");
      check("cursor dots", seg[ptr[i][3:0]*5 +: 5], 5'h1f);
    end
  endtask
  task automatic wait_kd(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (kd_oe_n !== lvl && n < 3000);
    if (n >= 3000) fail_wait("key line");
    repeat (100) @(posedge clk);
  endtask
  task automatic press(input logic [35:0] k, input logic [31:0] exp);
    keys <= k;
    wait_kd(1'b0);
    check("key irq", irq, 32'h1);
    rdc("key data", `LCDK_OFS_KEY, exp);
    rdc("press irq", `LCDK_OFS_IRQ_STAT, 32'h1);
    keys <= '0;
    wait_kd(1'b1);
    rdc("release irq", `LCDK_OFS_IRQ_STAT, 32'h2);
  endtask
  task automatic t_keys();
    apb(1'b0, `LCDK_OFS_IRQ_STAT, 32'h0);
    apb(1'b1, `LCDK_OFS_IRQ_MASK, 32'h3);
    press(36'h1 << 8, 32'h1102);
    press((36'h1 << 8) | (36'h1 << 22), 32'h150a);
    press((36'h1 << 10) | (36'h1 << 20), 32'h150a);
  endtask
  initial begin
    req = '0;
    keys = '0;
    rst_n = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_standby();
    t_pointer();
    scan_com(17'h1ffff);
    t_cursor();
    cmd(`LCDK_OFS_CTRL, 32'h5a);
    scan_com(17'h001ff);
    t_keys();
    test_done();
  end
endmodule
bind lcdk_core lcdk_core_chk i_lcdk_core_chk (.CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN),
  .APB_REQ_IN(APB_REQ_IN), .APB_RSP_OUT(APB_RSP_OUT), .COM_OUT(COM_OUT), .SEG_OUT(SEG_OUT),
  .LED_OUT(LED_OUT), .KEY_ROW_OUT(KEY_ROW_OUT), .KEY_ROW_OE_N_OUT(KEY_ROW_OE_N_OUT),
  .KD_OUT(KD_OUT));
